// file: hdl/flash_access_pkg.sv
// Purpose: Constants for the nonvolatile access and security block
// Assumes: One 250 MHz core clock, synchronous active-low reset
// Notes:   Codes, counts and states below; codes are command register values
package flash_access_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ       = 8'h01;
  localparam logic [7:0] CMD_WRITE      = 8'h02;
  localparam logic [7:0] CMD_VERIFY     = 8'h04;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL  = 8'h06;
  localparam logic [7:0] CMD_READ_BYTE  = 8'h81;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h82;
  localparam logic [7:0] CMD_LEAVE_UDL  = 8'h0F;
  localparam logic [7:0] CMD_ENTER_UDL  = 8'hF0;
  localparam logic [7:0] VERIFY_FAIL    = 8'h01;  // Nonzero verify answer
  // Reset values
  localparam logic [7:0]  CMD_RST  = 8'h00;
  localparam logic [15:0] VEC_RST  = 16'h0000;
  localparam logic [15:0] VEC_BOOT = 16'hE000;   // Boot loader entry
  // Security bit positions
  localparam int SEC_LOCK   = 0;
  localparam int SEC_SECURE = 1;
  localparam int SEC_SAFE   = 2;
  // Counts
  localparam logic [9:0] BOOT_SETTLE  = 10'h003;  // Cycles before strap read
  localparam logic [9:0] LAST_PAGE    = 10'h3FF;  // 1024 data pages
  localparam logic [9:0] LAST_COPY    = 10'h0FF;  // 256 copied bytes
  localparam logic [7:0] PROT_PAGE_HI = 8'hE0;    // Code pages at and above are protected
  // Code memory operations
  localparam logic [1:0] COP_PROG      = 2'h0;
  localparam logic [1:0] COP_ERASE_PG  = 2'h1;
  localparam logic [1:0] COP_ERASE_ALL = 2'h2;
  // Controller states
  typedef enum logic [3:0] {
    ST_BOOT  = 4'h1,
    ST_IDLE  = 4'h2,
    ST_ERASE = 4'h4,
    ST_COPY  = 4'h8
  } state_e;
endpackage

// file: hdl/flash_access_security_control.sv
// Purpose: Command, page and security control for code and data flash
// Assumes: Code array lives outside; XRAM_DATA_I answers XRAM_ADDR_O in the same cycle
// Notes:   Data array is held here; security bits are loaded at boot
`timescale 1ns/1ns
`default_nettype none
module flash_access_security_control #(
  parameter int CODE_KB = 62   // Memory option: 62, 32 or 8
) (
  input  wire logic        CORE_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        BOOT_SELECT_STROBE_N_I,  // Pin, low asks for download
  input  wire logic        BOOT_OPT_I,              // Always start at boot loader
  input  wire logic [2:0]  SEC_NV_I,                // Stored security bits
  input  wire logic [2:0]  SEC_SET_I,               // Enable pulses from protocols
  input  wire logic        CODE_ERASE_SER_I,        // Code-erase in serial download
  input  wire logic        CODE_ERASE_PAR_I,        // Code-erase in parallel mode
  input  wire logic        CMD_WR_I,
  input  wire logic        ADDR_H_WR_I,
  input  wire logic        ADDR_L_WR_I,
  input  wire logic [3:0]  DATA_WR_I,
  input  wire logic [7:0]  SFR_WDATA_I,
  input  wire logic [7:0]  XRAM_DATA_I,
  output logic [7:0]       FLASH_COMMAND_REG_O,
  output logic [7:0]       FLASH_PAGE_ADDR_HIGH_O,
  output logic [7:0]       FLASH_PAGE_ADDR_LOW_O,
  output logic [31:0]      FLASH_PAGE_DATA_BYTES_O,
  output logic             USER_DOWNLOAD_MODE_O,
  output logic             BUSY_O,
  output logic             BOOT_DONE_O,
  output logic             SERIAL_DL_O,
  output logic [15:0]      RESET_VECTOR_O,
  output logic [2:0]       SEC_STATE_O,
  output logic             PP_PROG_OK_O,
  output logic             PP_READ_OK_O,
  output logic             EXT_CODE_READ_OK_O,
  output logic             EXT_DATA_OK_O,
  output logic [7:0]       XRAM_ADDR_O,
  output logic             CODE_STB_O,
  output logic [1:0]       CODE_OP_O,
  output logic [15:0]      CODE_ADDR_O,
  output logic [7:0]       CODE_DATA_O,
  output logic             CMD_REJECT_O
);
  // User region bounds in 256-byte code pages
  localparam logic       USER_EN = (CODE_KB != 8);
  localparam logic [7:0] USER_LO = (CODE_KB == 62) ? 8'h00 : 8'((CODE_KB - 8) * 4);
  localparam logic [7:0] USER_HI = (CODE_KB == 62) ? 8'hE0 : 8'(CODE_KB * 4);
  localparam logic [16:0] CODE_LIMIT = 17'(CODE_KB * 1024);  // End of code array

  typedef struct packed {
    flash_access_pkg::state_e st;
    logic [2:0]  sync;      // Strap synchroniser, bit 0 first
    logic [9:0]  cnt;       // Settle, erase and copy counter
    logic [7:0]  cmd;       // Command register
    logic [7:0]  ah;        // Page address high
    logic [7:0]  al;        // Page address low
    logic [31:0] dat;       // Four page data bytes
    logic        udl;       // User download mode
    logic [2:0]  sec;       // Lock, secure, serial safe
    logic        done;      // Boot decision taken
    logic        ser;       // Serial download chosen
    logic [15:0] vec;       // Start address
    logic        stb;       // Code operation pulse
    logic [1:0]  op;
    logic [15:0] caddr;
    logic [7:0]  cdata;
    logic        rej;       // Refused code write pulse
  } ctl_s;

  ctl_s        r_ff;
  ctl_s        nxt_r;
  logic [7:0]  dmem [0:4095];   // Data flash, 1024 pages of 4 bytes
  logic [3:0]  mem_we;          // Byte lane write enables
  logic [9:0]  mem_page;        // Page being written
  logic [31:0] mem_wdat;        // Final lane values
  logic [9:0]  rd_pg;           // Page being read
  logic [31:0] rd_page;         // Current content of rd_pg
  logic [11:0] baddr;           // Byte address for byte commands
  logic        byte_cmd;
  logic        valid_cmd;
  logic [7:0]  rd_byte;

  // Address forms and array read
  always_comb begin
    baddr    = {r_ff.ah[3:0], r_ff.al};
    byte_cmd = (SFR_WDATA_I == flash_access_pkg::CMD_READ_BYTE) ||
               (SFR_WDATA_I == flash_access_pkg::CMD_WRITE_BYTE);
    rd_pg    = byte_cmd ? baddr[11:2] : {r_ff.ah[1:0], r_ff.al};
    rd_page  = {dmem[{rd_pg, 2'h3}], dmem[{rd_pg, 2'h2}],
                dmem[{rd_pg, 2'h1}], dmem[{rd_pg, 2'h0}]};
    rd_byte  = rd_page[8*baddr[1:0] +: 8];
    // Only the nine documented codes count
    unique case (SFR_WDATA_I)
      flash_access_pkg::CMD_READ, flash_access_pkg::CMD_WRITE, flash_access_pkg::CMD_VERIFY,
      flash_access_pkg::CMD_ERASE_PAGE, flash_access_pkg::CMD_ERASE_ALL,
      flash_access_pkg::CMD_READ_BYTE, flash_access_pkg::CMD_WRITE_BYTE,
      flash_access_pkg::CMD_LEAVE_UDL, flash_access_pkg::CMD_ENTER_UDL: valid_cmd = 1'b1;
      default: valid_cmd = 1'b0;
    endcase
  end

  // Next-state logic
  always_comb begin
    nxt_r      = r_ff;
    nxt_r.stb  = 1'b0;
    nxt_r.rej  = 1'b0;
    nxt_r.sync = {r_ff.sync[1:0], BOOT_SELECT_STROBE_N_I};
    mem_we     = 4'h0;
    mem_page   = rd_pg;
    mem_wdat   = 32'hFFFFFFFF;
    // Register writes from software
    if (ADDR_H_WR_I) nxt_r.ah = SFR_WDATA_I;
    if (ADDR_L_WR_I) nxt_r.al = SFR_WDATA_I;
    for (int i = 0; i < 4; i++) begin
      if (DATA_WR_I[i]) nxt_r.dat[8*i +: 8] = SFR_WDATA_I;
    end
    unique case (r_ff.st)
      flash_access_pkg::ST_BOOT: begin
        // Wait for the strap to settle, then decide start mode
        if (r_ff.cnt < flash_access_pkg::BOOT_SETTLE) begin
          nxt_r.cnt = r_ff.cnt + 10'h001;
        end else if (r_ff.sync[1] == r_ff.sync[2]) begin
          nxt_r.sec  = SEC_NV_I;
          nxt_r.ser  = !r_ff.sync[2] && !SEC_NV_I[flash_access_pkg::SEC_SAFE];
          nxt_r.vec  = BOOT_OPT_I ? flash_access_pkg::VEC_BOOT
                                  : flash_access_pkg::VEC_RST;
          nxt_r.done = 1'b1;
          nxt_r.cnt  = 10'h000;
          nxt_r.st   = flash_access_pkg::ST_IDLE;
        end
      end
      flash_access_pkg::ST_IDLE: begin
        if (CMD_WR_I && valid_cmd) begin    // Others ignored
          nxt_r.cmd = SFR_WDATA_I;
          if (SFR_WDATA_I == flash_access_pkg::CMD_ENTER_UDL) begin
            nxt_r.udl = 1'b1;
          end else if (SFR_WDATA_I == flash_access_pkg::CMD_LEAVE_UDL) begin
            nxt_r.udl = 1'b0;
          end else if (!r_ff.udl) begin
            // Data memory commands
            unique case (SFR_WDATA_I)
              flash_access_pkg::CMD_READ: nxt_r.dat = rd_page;
              flash_access_pkg::CMD_WRITE: begin
                mem_we   = 4'hF;
                mem_wdat = r_ff.dat & rd_page;   // Programming only clears bits
              end
              flash_access_pkg::CMD_VERIFY:
                nxt_r.cmd = (r_ff.dat == rd_page) ? 8'h00 : flash_access_pkg::VERIFY_FAIL;
              flash_access_pkg::CMD_ERASE_PAGE: mem_we = 4'hF;
              flash_access_pkg::CMD_ERASE_ALL: begin
                nxt_r.cnt = 10'h000;
                nxt_r.st  = flash_access_pkg::ST_ERASE;
              end
              flash_access_pkg::CMD_READ_BYTE: nxt_r.dat[7:0] = rd_byte;
              default: begin                     // Byte write
                mem_we[baddr[1:0]] = 1'b1;
                mem_wdat = {4{r_ff.dat[7:0] & rd_byte}};
              end
            endcase
          end else begin
            // Code memory commands, region checked
            unique case (SFR_WDATA_I)
              flash_access_pkg::CMD_WRITE: begin
                if (USER_EN && r_ff.ah >= USER_LO && r_ff.ah < USER_HI) begin
                  nxt_r.caddr = {r_ff.ah, 8'h00};
                  nxt_r.cnt   = 10'h000;
                  nxt_r.st    = flash_access_pkg::ST_COPY;
                end else begin
                  nxt_r.rej = 1'b1;
                end
              end
              flash_access_pkg::CMD_ERASE_PAGE, flash_access_pkg::CMD_WRITE_BYTE: begin
                if (USER_EN && r_ff.ah >= USER_LO && r_ff.ah < USER_HI) begin
                  nxt_r.stb = 1'b1;
                  nxt_r.op  = (SFR_WDATA_I == flash_access_pkg::CMD_WRITE_BYTE) ?
                              flash_access_pkg::COP_PROG : flash_access_pkg::COP_ERASE_PG;
                  nxt_r.caddr = (SFR_WDATA_I == flash_access_pkg::CMD_WRITE_BYTE) ?
                                {r_ff.ah, r_ff.al} : {r_ff.ah, r_ff.al[7:6], 6'h00};
                  nxt_r.cdata = r_ff.dat[7:0];
                end else begin
                  nxt_r.rej = 1'b1;
                end
              end
              flash_access_pkg::CMD_ERASE_ALL: begin
                nxt_r.stb   = USER_EN;
                nxt_r.rej   = !USER_EN;
                nxt_r.op    = flash_access_pkg::COP_ERASE_ALL;
                nxt_r.caddr = {USER_LO, 8'h00};
              end
              default: ;                         // Reads and verify act through code reads
            endcase
          end
        end
      end
      flash_access_pkg::ST_ERASE: begin
        // Erase one data page per cycle
        mem_page  = r_ff.cnt;
        mem_we    = 4'hF;
        nxt_r.cnt = r_ff.cnt + 10'h001;
        if (r_ff.cnt == flash_access_pkg::LAST_PAGE) nxt_r.st = flash_access_pkg::ST_IDLE;
      end
      default: begin
        // Copy one RAM byte per cycle into the code page
        nxt_r.stb   = 1'b1;
        nxt_r.op    = flash_access_pkg::COP_PROG;
        nxt_r.caddr = {r_ff.caddr[15:8], r_ff.cnt[7:0]};
        nxt_r.cdata = XRAM_DATA_I;
        nxt_r.cnt   = r_ff.cnt + 10'h001;
        if (r_ff.cnt == flash_access_pkg::LAST_COPY) nxt_r.st = flash_access_pkg::ST_IDLE;
      end
    endcase
    // Security bits: clears first so a set in the same cycle wins
    if (r_ff.done) begin
      if (CODE_ERASE_SER_I || CODE_ERASE_PAR_I) begin
        nxt_r.sec[flash_access_pkg::SEC_LOCK]   = 1'b0;
        nxt_r.sec[flash_access_pkg::SEC_SECURE] = 1'b0;
      end
      if (CODE_ERASE_PAR_I) nxt_r.sec[flash_access_pkg::SEC_SAFE] = 1'b0;
      nxt_r.sec = nxt_r.sec | SEC_SET_I;
    end
  end

  // State register
  always_ff @(posedge CORE_CLK_I) begin
    if (!RESETN_I) begin
      r_ff       <= '0;
      r_ff.st    <= flash_access_pkg::ST_BOOT;
      r_ff.sync  <= 3'h7;
      r_ff.cmd   <= flash_access_pkg::CMD_RST;
      r_ff.vec   <= flash_access_pkg::VEC_RST;
    end else begin
      r_ff <= nxt_r;
    end
  end

  // Data array writes, no reset since the array is nonvolatile
  always_ff @(posedge CORE_CLK_I) begin
    for (int i = 0; i < 4; i++) begin
      if (mem_we[i]) dmem[{mem_page, 2'(i)}] <= mem_wdat[8*i +: 8];
    end
  end

  // Outputs
  always_comb begin
    FLASH_COMMAND_REG_O     = r_ff.cmd;
    FLASH_PAGE_ADDR_HIGH_O  = r_ff.ah;
    FLASH_PAGE_ADDR_LOW_O   = r_ff.al;
    FLASH_PAGE_DATA_BYTES_O = r_ff.dat;
    USER_DOWNLOAD_MODE_O    = r_ff.udl;
    BUSY_O                  = (r_ff.st != flash_access_pkg::ST_IDLE);
    BOOT_DONE_O             = r_ff.done;
    SERIAL_DL_O             = r_ff.ser;
    RESET_VECTOR_O          = r_ff.vec;
    SEC_STATE_O             = r_ff.sec;
    // Access gates for the parallel port and external code
    PP_PROG_OK_O       = r_ff.done && !r_ff.sec[flash_access_pkg::SEC_LOCK] &&
                         !r_ff.sec[flash_access_pkg::SEC_SECURE];
    PP_READ_OK_O       = r_ff.done && !r_ff.sec[flash_access_pkg::SEC_SECURE];
    EXT_CODE_READ_OK_O = r_ff.done && !r_ff.sec[flash_access_pkg::SEC_SECURE];
    EXT_DATA_OK_O      = r_ff.done && !r_ff.sec[flash_access_pkg::SEC_SECURE];
    XRAM_ADDR_O        = r_ff.cnt[7:0];
    CODE_STB_O         = r_ff.stb;
    CODE_OP_O          = r_ff.op;
    CODE_ADDR_O        = r_ff.caddr;
    CODE_DATA_O        = r_ff.cdata;
    CMD_REJECT_O       = r_ff.rej;
  end

  // Checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RESETN_I);

  property p_lock_prog;
    r_ff.sec[flash_access_pkg::SEC_LOCK] |-> !PP_PROG_OK_O;
  endproperty
  a_lock_prog: assert property (p_lock_prog) else $error("lock allows programming");
  property p_lock_read;
    r_ff.done && r_ff.sec == 3'h1 |-> PP_READ_OK_O && EXT_CODE_READ_OK_O;
  endproperty
  a_lock_read: assert property (p_lock_read) else $error("lock blocks reads");
  property p_secure;
    r_ff.sec[flash_access_pkg::SEC_SECURE] |-> !PP_READ_OK_O && !EXT_DATA_OK_O && !PP_PROG_OK_O;
  endproperty
  a_secure: assert property (p_secure) else $error("secure leaks access");
  property p_safe_boot;
    $rose(BOOT_DONE_O) && SEC_STATE_O[flash_access_pkg::SEC_SAFE] |-> !SERIAL_DL_O;
  endproperty
  a_safe_boot: assert property (p_safe_boot) else $error("safe mode downloaded");
  property p_safe_hold;
    r_ff.done && r_ff.sec[flash_access_pkg::SEC_SAFE] && !CODE_ERASE_PAR_I |=> SEC_STATE_O[2];
  endproperty
  a_safe_hold: assert property (p_safe_hold) else $error("safe mode lost");
  property p_ro_normal;
    CMD_WR_I && !r_ff.udl && r_ff.st == flash_access_pkg::ST_IDLE |=> !CODE_STB_O ##1 !CODE_STB_O;
  endproperty
  a_ro_normal: assert property (p_ro_normal) else $error("code write outside download");
  property p_top_prot;
    CODE_STB_O && CODE_OP_O != flash_access_pkg::COP_ERASE_ALL |->
      CODE_ADDR_O[15:8] < flash_access_pkg::PROT_PAGE_HI;
  endproperty
  a_top_prot: assert property (p_top_prot) else $error("protected code written");
  property p_code_map;
    CODE_STB_O |-> {1'b0, CODE_ADDR_O} < CODE_LIMIT;
  endproperty
  a_code_map: assert property (p_code_map) else $error("code address beyond array");
  property p_copy;
    CMD_WR_I && SFR_WDATA_I == flash_access_pkg::CMD_WRITE && r_ff.udl &&
    r_ff.st == flash_access_pkg::ST_IDLE && !CMD_REJECT_O ##1 !CMD_REJECT_O |=> CODE_STB_O[*8];
  endproperty
  a_copy: assert property (p_copy) else $error("page copy stalled");
  property p_verify;
    CMD_WR_I && SFR_WDATA_I == flash_access_pkg::CMD_VERIFY && !r_ff.udl &&
    r_ff.st == flash_access_pkg::ST_IDLE |=>
      (FLASH_COMMAND_REG_O == 8'h00) == ($past(rd_page) == $past(r_ff.dat));
  endproperty
  a_verify: assert property (p_verify) else $error("verify answer wrong");
  property p_bad_cmd;
    CMD_WR_I && !valid_cmd && DATA_WR_I == 4'h0 && r_ff.st == flash_access_pkg::ST_IDLE |=>
      $stable(FLASH_PAGE_DATA_BYTES_O) && $stable(FLASH_COMMAND_REG_O) && !CODE_STB_O;
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command acted");

  c_serial_dl: cover property ($rose(SERIAL_DL_O));
  c_copy: cover property (r_ff.st == flash_access_pkg::ST_COPY && r_ff.cnt == 10'h0FF);
  c_erase_all: cover property (r_ff.st == flash_access_pkg::ST_ERASE && r_ff.cnt == 10'h3FF);
  c_verify_ok: cover property (CMD_WR_I && SFR_WDATA_I == 8'h04 ##1 FLASH_COMMAND_REG_O == 8'h00);
endmodule
`default_nettype wire

// file: tb/xram_model.sv
// Purpose: Stand-in for the internal RAM read by the copy engine
// Assumes: The byte answers the address in the same cycle
// Notes:   Also counts code-memory strobes so stray writes show up
`timescale 1ns/1ns
`default_nettype none
module xram_model (
  input  wire logic       core_clk_i,
  input  wire logic       code_stb_i,
  input  wire logic [7:0] xram_addr_i,
  output logic [7:0]      xram_data_o,
  output var int          n_stb_o
);
  // Fixed pattern, so neighbouring bytes always differ
  assign xram_data_o = xram_addr_i ^ 8'hA5;
  // Strobe counter, one driver only
  int n_stb = 0;
  assign n_stb_o = n_stb;
  always @(posedge core_clk_i) begin
    if (code_stb_i === 1'b1) begin
      n_stb <= n_stb + 1;
    end
  end
endmodule
`default_nettype wire

// file: tb/flash_access_security_control_tb.sv
// Purpose: Self-checking bench for the flash access and security block
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Data array is erased whole before any page is compared
`timescale 1ns/1ns
`default_nettype none
module flash_access_security_control_tb;
  logic        clk = 1'b0, rstn = 1'b0, pin = 1'b1, opt = 1'b0;   // Clock, reset, straps
  logic [2:0]  nv = 3'h0, sset = 3'h0;                            // Security inputs
  logic        ers = 1'b0, erp = 1'b0, cwr = 1'b0, ahw = 1'b0, alw = 1'b0;
  logic [3:0]  dwr = 4'h0;                                        // Byte write pulses
  logic [7:0]  wd = 8'h00, xd, creg, ah, al, xa, cdat;
  logic [31:0] dq;                                                // Page data bytes
  logic        udl, busy, done, sdl, ppp, ppr, exc, exd, stb, rej;
  logic [15:0] vec, cadr;
  logic [2:0]  sec;
  logic [1:0]  cop;
  logic        rej_seen, stb_seen;                                // Captured pulses
  int          n_stb, failures = 0, n_compared = 0;
  // Core clock, 4 ns period
  always #2 clk = ~clk;
  flash_access_security_control u_dut (.CORE_CLK_I(clk), .RESETN_I(rstn),
    .BOOT_SELECT_STROBE_N_I(pin), .BOOT_OPT_I(opt), .SEC_NV_I(nv), .SEC_SET_I(sset),
    .CODE_ERASE_SER_I(ers), .CODE_ERASE_PAR_I(erp), .CMD_WR_I(cwr), .ADDR_H_WR_I(ahw),
    .ADDR_L_WR_I(alw), .DATA_WR_I(dwr), .SFR_WDATA_I(wd), .XRAM_DATA_I(xd),
    .FLASH_COMMAND_REG_O(creg), .FLASH_PAGE_ADDR_HIGH_O(ah), .FLASH_PAGE_ADDR_LOW_O(al),
    .FLASH_PAGE_DATA_BYTES_O(dq), .USER_DOWNLOAD_MODE_O(udl), .BUSY_O(busy),
    .BOOT_DONE_O(done), .SERIAL_DL_O(sdl), .RESET_VECTOR_O(vec), .SEC_STATE_O(sec),
    .PP_PROG_OK_O(ppp), .PP_READ_OK_O(ppr), .EXT_CODE_READ_OK_O(exc), .EXT_DATA_OK_O(exd),
    .XRAM_ADDR_O(xa), .CODE_STB_O(stb), .CODE_OP_O(cop), .CODE_ADDR_O(cadr),
    .CODE_DATA_O(cdat), .CMD_REJECT_O(rej));
  xram_model u_xram (.core_clk_i(clk), .code_stb_i(stb), .xram_addr_i(xa),
    .xram_data_o(xd), .n_stb_o(n_stb));
  // Compare one value
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("compared %0d mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Step to just after the next edge
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for idle
  task automatic wait_idle();
    for (int i = 0; i < 2000; i++) begin
      if (busy === 1'b0) begin
        return;
      end
      tick();
    end
    failures++;
    close_out();
  endtask
  // Reset with given straps, then count edges to boot decision
  task automatic do_reset(input logic p, input logic o, input logic [2:0] n);
    int k;
    rstn = 1'b0;
    pin = p;
    opt = o;
    nv = n;
    repeat (3) tick();
    chk(creg, 32'h0);
    chk(udl, 32'h0);
    rstn = 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      tick();
      k++;
    end
    chk(k, 32'(flash_access_pkg::BOOT_SETTLE) + 32'h1);
    if (done !== 1'b1) close_out();
  endtask
  // Page address registers
  task automatic set_addr(input logic [7:0] h, input logic [7:0] l);
    ahw = 1'b1;
    wd = h;
    tick();
    ahw = 1'b0;
    alw = 1'b1;
    wd = l;
    tick();
    alw = 1'b0;
  endtask
  // Four data bytes, one per cycle
  task automatic set_data(input logic [31:0] d);
    for (int i = 0; i < 4; i++) begin
      dwr = 4'h1 << i;
      wd = d[8*i+:8];
      tick();
    end
    dwr = 4'h0;
  endtask
  // One command; pulses of the answer cycle are captured
  task automatic cmd(input logic [7:0] c);
    cwr = 1'b1;
    wd = c;
    tick();
    cwr = 1'b0;
    rej_seen = rej;
    stb_seen = stb;
    wait_idle();
    tick();  // Lets one more edge pass so any strobe is counted and low before the next command
  endtask
  // Boot straps, vector and serial download choice
  task automatic t_boot();
    do_reset(1'b1, 1'b1, 3'h0);
    chk(vec, flash_access_pkg::VEC_BOOT);
    chk(sdl, 32'h0);
    do_reset(1'b0, 1'b0, 3'h0);
    chk(sdl, 32'h1);
    chk(vec, flash_access_pkg::VEC_RST);
    do_reset(1'b0, 1'b0, 3'h4);
    chk(sdl, 32'h0);
    chk(sec, 32'h4);
    do_reset(1'b1, 1'b0, 3'h0);
    $display("test boot finished");
  endtask
  // Data array commands on the last page
  task automatic t_data();
    cmd(flash_access_pkg::CMD_ERASE_ALL);
    set_addr(8'h03, 8'hFF);
    chk({ah, al}, 32'h03FF);
    cmd(flash_access_pkg::CMD_READ);
    chk(dq, 32'hFFFFFFFF);
    set_data(32'h12F35A00);  // Erased first, as software must
    cmd(flash_access_pkg::CMD_WRITE);
    set_data(32'h0);
    cmd(flash_access_pkg::CMD_READ);
    chk(dq, 32'h12F35A00);
    cmd(flash_access_pkg::CMD_VERIFY);
    chk(creg, 32'h0);
    set_data(32'h12F35A01);
    cmd(flash_access_pkg::CMD_VERIFY);
    chk(creg, flash_access_pkg::VERIFY_FAIL);
    cmd(flash_access_pkg::CMD_ERASE_PAGE);
    cmd(flash_access_pkg::CMD_READ);
    chk(dq, 32'hFFFFFFFF);
    set_addr(8'h0F, 8'hFE);
    set_data(32'hA7);
    cmd(flash_access_pkg::CMD_WRITE_BYTE);
    set_data(32'h0);
    cmd(flash_access_pkg::CMD_READ_BYTE);
    chk(dq, 32'hA7);
    set_addr(8'h03, 8'hFF);
    cmd(flash_access_pkg::CMD_READ);
    chk(dq, 32'hFFA7FFFF);
    set_data(32'h0);
    cmd(8'h03);
    chk(creg, flash_access_pkg::CMD_READ);
    chk(dq, 32'h0);
    chk(n_stb, 0);
    $display("test data finished");
  endtask
  // User download: copy, protected top, erase all, leave
  task automatic t_udl();
    int k;
    int s;
    logic [7:0] c3 [3] = '{flash_access_pkg::CMD_WRITE, flash_access_pkg::CMD_WRITE_BYTE,
                           flash_access_pkg::CMD_ERASE_PAGE};
    cmd(flash_access_pkg::CMD_ENTER_UDL);
    chk(udl, 32'h1);
    set_addr(8'h10, 8'h00);
    cwr = 1'b1;
    wd = flash_access_pkg::CMD_WRITE;
    tick();
    cwr = 1'b0;
    k = 0;
    for (int i = 0; i < 300; i++) begin
      if (stb === 1'b1) begin
        chk({cop, cadr, cdat}, {flash_access_pkg::COP_PROG, 8'h10, k[7:0], k[7:0] ^ 8'hA5});
        k++;
      end
      if (busy === 1'b0) begin
        break;
      end
      tick();
    end
    if (busy !== 1'b0) begin
      failures++;
      close_out();
    end
    chk(k, 256);
    for (int i = 0; i < 3; i++) begin
      set_addr(8'hE0, 8'h00);
      s = n_stb;
      cmd(c3[i]);
      chk(rej_seen, 32'h1);
      chk(n_stb, s);
    end
    set_addr(8'hDF, 8'hFF);
    set_data(32'h5C);
    cmd(flash_access_pkg::CMD_WRITE_BYTE);
    chk({stb_seen, cop, cadr, cdat}, {1'b1, flash_access_pkg::COP_PROG, 24'hDFFF5C});
    cmd(flash_access_pkg::CMD_ERASE_ALL);
    chk({stb_seen, cop}, {1'b1, flash_access_pkg::COP_ERASE_ALL});
    cmd(flash_access_pkg::CMD_LEAVE_UDL);
    chk(udl, 32'h0);
    $display("test download finished");
  endtask
  // Security set and clear pulses
  task automatic sec_pulse(input logic [2:0] s, input logic se, input logic pe);
    sset = s;
    ers = se;
    erp = pe;
    tick();
    sset = 3'h0;
    ers = 1'b0;
    erp = 1'b0;
    tick();  // Lets an edge pass with the pulses low before the next call
  endtask
  task automatic t_sec();
    chk(ppp, 32'h1);
    sec_pulse(3'h1, 1'b0, 1'b0);
    chk({ppp, ppr, exc}, 32'h3);
    sec_pulse(3'h0, 1'b1, 1'b0);
    chk(sec, 32'h0);
    sec_pulse(3'h2, 1'b0, 1'b0);
    chk({ppp, ppr, exc, exd}, 32'h0);
    sec_pulse(3'h4, 1'b0, 1'b0);
    chk(sec, 32'h6);
    sec_pulse(3'h0, 1'b1, 1'b0);
    chk(sec, 32'h4);
    sec_pulse(3'h0, 1'b0, 1'b1);
    chk(sec, 32'h0);
    sec_pulse(3'h1, 1'b1, 1'b0);
    chk(sec, 32'h1);
    $display("test security finished");
  endtask
  // Main sequence
  initial begin
    t_boot();
    t_data();
    t_udl();
    t_sec();
    close_out();
  end
endmodule
`default_nettype wire
